//--- include/cmf_pkg.sv
/*
 * Package for the CAN controller mode and acceptance-filter configuration block.
 * Holds register offsets, field positions, reset values and mode encodings.
 * Assumes a 32-bit APB slave; each register takes one aligned word.
 */
// ----------------------------------------------------------------------------
// Notes on behaviour
// ----------------------------------------------------------------------------
package cmf_pkg;

    // ------------------------------------------------------------------------
    // Operating modes.
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h0,
        MODE_SLEEP = 3'h1,
        MODE_LOOP = 3'h2,
        MODE_LISTEN = 3'h3,
        MODE_CONFIG = 3'h4
    } cmf_mode_t;

    // ------------------------------------------------------------------------
    // Register byte offsets.
    // ------------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_TXPRI = 8'h08;
    localparam logic [7:0] OFF_TXREQ = 8'h0c;
    localparam logic [7:0] OFF_SEQ_ADDR = 8'h10;
    localparam logic [7:0] OFF_SEQ_CNT = 8'h14;
    localparam logic [7:0] OFF_SEQ_DATA = 8'h18;
    localparam logic [7:0] OFF_MASK0 = 8'h20;
    localparam logic [7:0] OFF_MASK1 = 8'h24;
    localparam logic [7:0] OFF_FILT0 = 8'h28;
    localparam logic [7:0] OFF_FILT_LAST = 8'h3c;

    // Field positions.
    localparam int REQ_MODE_LSB = 5;
    localparam int CUR_MODE_LSB = 5;
    localparam int PRI_W = 2;
    localparam int ID_W = 29;
    localparam int NUM_TX = 3;
    localparam int NUM_FILT = 6;

    // Reset values.
    localparam cmf_mode_t MODE_RESET = MODE_CONFIG;
    localparam logic [28:0] ACC_RESET = 29'h0;
    localparam logic [7:0] SEQ_CNT_RESET = 8'h00;

endpackage

//--- logic/cmf_acceptance.sv
/*
 * Acceptance check for both receive buffers.
 * Assumes masks and filters are held stable by the caller.
 */
`timescale 1ns/1ps
module cmf_acceptance (
    input wire logic [28:0] rxId,      // Identifier under test.
    input wire logic [28:0] mask0,     // First buffer mask.
    input wire logic [28:0] mask1,     // Second buffer mask.
    input wire logic [28:0] filt [6],  // Six acceptance filters.
    output logic hitFirst,             // Accepted by first buffer.
    output logic hitSecond             // Accepted by second buffer.
);
    logic [5:0] match;

    // A filter matches when every masked bit agrees.
    genvar g;
    generate
        for (g = 0; g < cmf_pkg::NUM_FILT; g++) begin : gMatch
            logic [28:0] m;
            assign m = (g < 2) ? mask0 : mask1;
            assign match[g] = ((rxId ^ filt[g]) & m) == 29'h0;
        end
    endgenerate

    // Filters a,b feed the first buffer; c..f feed the second.
    assign hitFirst = |match[1:0];
    assign hitSecond = |match[5:2];
endmodule

//--- logic/cmf_mode_filter.sv
/*
 * Mode control, acceptance configuration, transmit priority and sequential
 * register access of a CAN controller, behind an APB slave.
 * Assumes the protocol engine reports finished transmissions and frame events.
 */
`timescale 1ns/1ps
module cmf_mode_filter (
    input wire logic clk,                 // 25 MHz clock.
    input wire logic reset_n,             // Synchronous reset, active low.
    input wire logic psel,                // APB select.
    input wire logic penable,             // APB enable.
    input wire logic pwrite,              // APB direction.
    input wire logic [7:0] paddr,         // APB byte address.
    input wire logic [31:0] pwdata,       // APB write data.
    output logic [31:0] prdata,           // APB read data.
    output logic pready,                  // APB ready.
    output logic pslverr,                 // APB error.
    input wire logic [2:0] txDone,        // Engine finished buffer, pulse.
    input wire logic rxValid,             // Frame received, pulse.
    input wire logic [28:0] rxId,         // Received identifier.
    output logic [2:0] txPending,         // Transmit requests outstanding.
    output logic [5:0] txPrio,            // Priorities of the three buffers.
    output logic txEnable,                // Engine may drive the bus.
    output logic loopEnable,              // Route transmit to receiver.
    output logic rxEnable,                // Engine may receive.
    output logic rxAcceptFirst,           // Frame kept in first buffer.
    output logic rxAcceptSecond           // Frame kept in second buffer.
);
    // ------------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------------
    cmf_pkg::cmf_mode_t reqMode_q, curMode_q;
    logic [28:0] mask0_q, mask1_q;
    logic [28:0] filt_q [6];
    logic [5:0] prio_q;
    logic [2:0] txReq_q;
    logic [7:0] seqAddr_q;
    logic [7:0] seqCnt_q;
    logic [31:0] rdata_d;
    logic rdOk;
    logic hitFirst, hitSecond;

    // An access completes in its first access cycle; pready is a flop.
    logic setup, access;
    assign setup = psel & ~penable;
    assign access = psel & penable & pready;

    // Effective address: the data window redirects to the sequential pointer.
    logic [7:0] effAddr;
    logic isSeq;
    assign isSeq = (paddr == cmf_pkg::OFF_SEQ_DATA);
    assign effAddr = isSeq ? seqAddr_q : paddr;

    logic wr;
    assign wr = access & pwrite & (~isSeq | (seqCnt_q != 8'h00));

    logic inConfig;
    assign inConfig = (curMode_q == cmf_pkg::MODE_CONFIG);

    // ------------------------------------------------------------------------
    // APB handshake: no wait state, ready in the first access cycle.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    // Read mux over the effective address.
    always_comb begin
        rdata_d = 32'h0;
        rdOk = 1'b1;
        case (effAddr)
            cmf_pkg::OFF_CTRL: rdata_d[cmf_pkg::REQ_MODE_LSB +: 3] = reqMode_q;
            cmf_pkg::OFF_STAT: rdata_d[cmf_pkg::CUR_MODE_LSB +: 3] = curMode_q;
            cmf_pkg::OFF_TXPRI: rdata_d[5:0] = prio_q;
            cmf_pkg::OFF_TXREQ: rdata_d[2:0] = txReq_q;
            cmf_pkg::OFF_SEQ_ADDR: rdata_d[7:0] = seqAddr_q;
            cmf_pkg::OFF_SEQ_CNT: rdata_d[7:0] = seqCnt_q;
            cmf_pkg::OFF_MASK0: rdata_d[28:0] = mask0_q;
            cmf_pkg::OFF_MASK1: rdata_d[28:0] = mask1_q;
            default: begin
                if (effAddr >= cmf_pkg::OFF_FILT0 && effAddr <= cmf_pkg::OFF_FILT_LAST
                        && effAddr[1:0] == 2'b00) begin
                    rdata_d[28:0] = filt_q[3'(effAddr[5:2] - 4'ha)];
                end else begin
                    rdOk = 1'b0;
                end
            end
        endcase
    end

    // Read data and error are captured at setup so they come from flops.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h0 : rdata_d;
            pslverr <= ~rdOk;
        end
    end

    // ------------------------------------------------------------------------
    // Mode request and mode switch.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reqMode_q <= cmf_pkg::MODE_RESET;
        end else if (wr && effAddr == cmf_pkg::OFF_CTRL) begin
            // Undefined codes are ignored so the request stays a legal mode.
            case (pwdata[cmf_pkg::REQ_MODE_LSB +: 3])
                3'h0, 3'h1, 3'h2, 3'h3, 3'h4:
                    reqMode_q <= cmf_pkg::cmf_mode_t'(pwdata[cmf_pkg::REQ_MODE_LSB +: 3]);
                default: reqMode_q <= reqMode_q;
            endcase
        end
    end

    // The mode only moves once no transmission is outstanding; this avoids
    // cutting a frame in half on the bus.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            curMode_q <= cmf_pkg::MODE_RESET;
        end else if (txReq_q == 3'h0 && curMode_q != reqMode_q) begin
            curMode_q <= reqMode_q;
        end
    end

    // Transmit requests: set by software in normal or loopback mode, cleared
    // by the engine. A completion and a new request in one cycle leave it set.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            txReq_q <= 3'h0;
        end else begin
            for (int i = 0; i < cmf_pkg::NUM_TX; i++) begin
                if (wr && effAddr == cmf_pkg::OFF_TXREQ && pwdata[i]
                        && (curMode_q == cmf_pkg::MODE_NORMAL
                            || curMode_q == cmf_pkg::MODE_LOOP)) begin
                    txReq_q[i] <= 1'b1;
                end else if (txDone[i]) begin
                    txReq_q[i] <= 1'b0;
                end
            end
        end
    end

    // Priority of each transmit buffer, writable in any mode.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prio_q <= 6'h0;
        end else if (wr && effAddr == cmf_pkg::OFF_TXPRI) begin
            prio_q <= pwdata[5:0];
        end
    end

    // ------------------------------------------------------------------------
    // Acceptance masks and filters, locked outside configuration mode.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mask0_q <= cmf_pkg::ACC_RESET;
            mask1_q <= cmf_pkg::ACC_RESET;
            for (int i = 0; i < cmf_pkg::NUM_FILT; i++) begin
                filt_q[i] <= cmf_pkg::ACC_RESET;
            end
        end else if (wr && inConfig) begin
            if (effAddr == cmf_pkg::OFF_MASK0) begin
                mask0_q <= pwdata[28:0];
            end
            if (effAddr == cmf_pkg::OFF_MASK1) begin
                mask1_q <= pwdata[28:0];
            end
            for (int i = 0; i < cmf_pkg::NUM_FILT; i++) begin
                if (effAddr == cmf_pkg::OFF_FILT0 + 8'(4 * i)) begin
                    filt_q[i] <= pwdata[28:0];
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Sequential access: each data-window access walks one word onward while the count is nonzero.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            seqAddr_q <= 8'h0;
            seqCnt_q <= cmf_pkg::SEQ_CNT_RESET;
        end else if (access && isSeq && seqCnt_q != 8'h00) begin
            seqAddr_q <= seqAddr_q + 8'h04;
            seqCnt_q <= seqCnt_q - 8'h01;
        end else if (wr && paddr == cmf_pkg::OFF_SEQ_ADDR) begin
            seqAddr_q <= {pwdata[7:2], 2'b00};
        end else if (wr && paddr == cmf_pkg::OFF_SEQ_CNT) begin
            seqCnt_q <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------------------
    // Engine controls and receive acceptance.
    // ------------------------------------------------------------------------
    cmf_acceptance uAcc (
        .rxId(rxId),
        .mask0(mask0_q),
        .mask1(mask1_q),
        .filt(filt_q),
        .hitFirst(hitFirst),
        .hitSecond(hitSecond)
    );

    // Listen-only never drives; loopback keeps frames inside.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            txEnable <= 1'b0;
            loopEnable <= 1'b0;
            rxEnable <= 1'b0;
            txPending <= 3'h0;
            txPrio <= 6'h0;
        end else begin
            txEnable <= (curMode_q == cmf_pkg::MODE_NORMAL);
            loopEnable <= (curMode_q == cmf_pkg::MODE_LOOP);
            rxEnable <= (curMode_q == cmf_pkg::MODE_NORMAL)
                || (curMode_q == cmf_pkg::MODE_LISTEN)
                || (curMode_q == cmf_pkg::MODE_LOOP);
            txPending <= txReq_q;
            txPrio <= prio_q;
        end
    end

    // Acceptance results are pulses, one cycle after the receive strobe.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rxAcceptFirst <= 1'b0;
            rxAcceptSecond <= 1'b0;
        end else begin
            rxAcceptFirst <= rxValid & rxEnable & hitFirst;
            rxAcceptSecond <= rxValid & rxEnable & ~hitFirst & hitSecond;
        end
    end
endmodule

//--- verification/cmf_assertions.sv
/* Port checker for the mode and acceptance block.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module cmf_assertions (
    input wire logic clk, // Clock.
    input wire logic reset_n, // Reset.
    input wire logic psel, // Select.
    input wire logic penable, // Enable.
    input wire logic pready, // Ready.
    input wire logic [2:0] txDone, // Done.
    input wire logic rxValid, // Frame in.
    input wire logic [2:0] txPending, // Pending.
    input wire logic txEnable, // May send.
    input wire logic loopEnable, // Loop.
    input wire logic rxEnable, // May receive.
    input wire logic rxAcceptFirst, // First hit.
    input wire logic rxAcceptSecond // Second hit.
);
    // --------
    // Relations
    // --------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // The slave answers in the first access cycle, for one cycle only.
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held");
    // Loopback keeps frames off the bus, and every sending mode also receives.
    loop_no_tx_a: assert property (!(txEnable && loopEnable))
        else $error("bus driven in loopback");
    send_recv_a: assert property (txEnable || loopEnable |-> rxEnable)
        else $error("sender not receiving");
    // While requests stay pending the mode outputs may not move.
    mode_hold_a: assert property ($past(txPending) != 3'h0 && txPending != 3'h0
        |-> $stable({txEnable, loopEnable, rxEnable})) else $error("mode moved while pending");
    // A request bit drops two cycles after its done pulse: one cycle for the
    // request flop and one for the registered output.
    pend_clear_a: assert property (
        (~txPending & $past(txPending) & ~$past(txDone, 2)) == 3'h0) else $error("request lost");
    // Acceptance pulses follow a frame by one cycle and never both at once.
    accept_timing_a: assert property (
        rxAcceptFirst || rxAcceptSecond |-> $past(rxValid)) else $error("hit without frame");
    accept_one_a: assert property (!(rxAcceptFirst && rxAcceptSecond))
        else $error("both buffers hit");
    cover property (rxAcceptFirst);
    cover property (rxAcceptSecond);
    cover property (loopEnable && txDone != 3'h0);
endmodule
bind cmf_mode_filter cmf_assertions chk_i (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pready(pready), .txDone(txDone), .rxValid(rxValid),
    .txPending(txPending), .txEnable(txEnable), .loopEnable(loopEnable), .rxEnable(rxEnable),
    .rxAcceptFirst(rxAcceptFirst), .rxAcceptSecond(rxAcceptSecond));

//--- verification/cmf_engine_model.sv
/* Behavioural protocol engine on the far side of the block.
   Assumes txPending stays up until its txDone pulse. */
`timescale 1ns/1ps
module cmf_engine_model (
    input wire logic clk, // Clock.
    input wire logic reset_n, // Reset, active low.
    input wire logic slow, // Long frames when high.
    input wire logic [2:0] txPending, // Requests.
    input wire logic txEnable, // Bus drive allowed.
    input wire logic loopEnable, // Internal loop.
    output logic [2:0] txDone // Completion pulse.
);
    // --------
    // Frame timing
    // --------
    logic [5:0] cnt_q;
    // Sends the lowest pending buffer after a frame time; a mode without send never ends one.
    always_ff @(posedge clk) begin
        txDone <= 3'h0;
        if (!reset_n || txPending == 3'h0 || txDone != 3'h0) begin
            cnt_q <= 6'h00;
        end else if (txEnable || loopEnable) begin
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == (slow ? 6'h1e : 6'h02)) begin
                txDone <= txPending & (~txPending + 3'h1);
            end
        end
    end
endmodule

//--- verification/tb.sv
/* Bench: APB sequences against the mode and filter block.
   Assumes the engine model on the far side. */
`timescale 1ns/1ps
module tb;
    // --------
    // Signals, tasks and sequence
    // --------
    logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic rxValid = 1'b0, slow = 1'b0, er, pready, pslverr, txEnable, loopEnable, rxEnable;
    logic rxAcceptFirst, rxAcceptSecond;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, v;
    logic [28:0] rxId = 29'h0;
    logic [2:0] txDone, txPending;
    logic [5:0] txPrio;
    cmf_pkg::cmf_mode_t old;
    cmf_pkg::cmf_mode_t seqm [5] = '{cmf_pkg::MODE_LISTEN, cmf_pkg::MODE_LOOP,
        cmf_pkg::MODE_NORMAL, cmf_pkg::MODE_SLEEP, cmf_pkg::MODE_CONFIG};
    int err_total = 0;
    int n_compared = 0;
    cmf_mode_filter uut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .txDone(txDone), .rxValid(rxValid), .rxId(rxId),
        .txPending(txPending), .txPrio(txPrio), .txEnable(txEnable), .loopEnable(loopEnable),
        .rxEnable(rxEnable), .rxAcceptFirst(rxAcceptFirst), .rxAcceptSecond(rxAcceptSecond));
    cmf_engine_model eng (.clk(clk), .reset_n(reset_n), .slow(slow), .txPending(txPending),
        .txEnable(txEnable), .loopEnable(loopEnable), .txDone(txDone));
    // 25 MHz clock.
    initial forever #20 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // A wait that runs out counts as a mismatch and closes the run.
    task automatic give_up();
        err_total++;
        give_verdict();
    endtask
    // One transfer; held until pready is sampled, then one idle cycle so no signal is set twice.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) give_up();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic waitidle();
        int n;
        n = 0;
        while (txPending !== 3'h0 && n < 500) begin
            @(posedge clk);
            n++;
        end
        if (n >= 500) give_up();
    endtask
    // A frame from the engine; the identifier is scrambled once the pulse is over.
    task automatic rx(input logic [28:0] id, input logic f, input logic s);
        rxId <= id;
        rxValid <= 1'b1;
        @(posedge clk);
        rxValid <= 1'b0;
        rxId <= ~id;
        @(posedge clk);
        chk({rxAcceptFirst, rxAcceptSecond}, {f, s});
    endtask
    task automatic rst();
        reset_n <= 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
    endtask
    // Configuration, normal traffic, walk through the modes, second reset.
    initial begin
        rst();
        rdc(cmf_pkg::OFF_STAT, 32'(cmf_pkg::MODE_RESET) << 5);
        for (int i = 0; i < 8; i++) begin
            v = (i < 2) ? 32'h1fff_ffff : 32'h0123_455e + i;
            wr(cmf_pkg::OFF_MASK0 + 8'(4 * i), v);
            rdc(cmf_pkg::OFF_MASK0 + 8'(4 * i), v);
        end
        wr(cmf_pkg::OFF_SEQ_ADDR, 32'(cmf_pkg::OFF_FILT0));
        wr(cmf_pkg::OFF_SEQ_CNT, 32'h2);
        for (int i = 1; i < 4; i++) wr(cmf_pkg::OFF_SEQ_DATA, 32'h0a00_0000 + i);
        rdc(cmf_pkg::OFF_FILT0 + 8'h08, 32'h0123_4562);
        wr(cmf_pkg::OFF_SEQ_ADDR, 32'(cmf_pkg::OFF_FILT0));
        wr(cmf_pkg::OFF_SEQ_CNT, 32'h2);
        for (int i = 1; i < 3; i++) rdc(cmf_pkg::OFF_SEQ_DATA, 32'h0a00_0000 + i);
        apb(1'b0, 8'h1c, 32'h0);
        chk(32'(er), 32'h1);
        $display("config test done");
        wr(cmf_pkg::OFF_CTRL, 32'h0);
        rdc(cmf_pkg::OFF_STAT, 32'h0);
        wr(cmf_pkg::OFF_MASK1, 32'h0);
        rdc(cmf_pkg::OFF_MASK1, 32'h1fff_ffff);
        rx(29'h0a00_0002, 1'b1, 1'b0);
        rx(29'h0123_4560, 1'b0, 1'b0);
        rx(29'h0123_4565, 1'b0, 1'b1);
        // Host-side reconfiguration: enter configuration, rewrite a mask, restore normal.
        wr(cmf_pkg::OFF_CTRL, 32'(cmf_pkg::MODE_CONFIG) << 5);
        rdc(cmf_pkg::OFF_STAT, 32'(cmf_pkg::MODE_CONFIG) << 5);
        wr(cmf_pkg::OFF_MASK1, 32'h0);
        wr(cmf_pkg::OFF_CTRL, 32'h0);
        rdc(cmf_pkg::OFF_STAT, 32'h0);
        rx(29'h0123_4560, 1'b0, 1'b1);
        for (int l = 0; l < 4; l++) begin
            v = 32'(l) | 32'(3 - l) << 2 | 32'(l) << 4;
            wr(cmf_pkg::OFF_TXPRI, v);
            rdc(cmf_pkg::OFF_TXPRI, v);
            chk(32'(txPrio), v);
        end
        wr(cmf_pkg::OFF_TXREQ, 32'h1);
        // The pending output is registered once more behind the request flop.
        @(posedge clk);
        chk(32'(txPending), 32'h1);
        waitidle();
        $display("normal test done");
        slow <= 1'b1;
        old = cmf_pkg::MODE_NORMAL;
        foreach (seqm[k]) begin
            wr(cmf_pkg::OFF_TXREQ, 32'h7);
            wr(cmf_pkg::OFF_CTRL, 32'(seqm[k]) << 5);
            v = 32'((old == cmf_pkg::MODE_NORMAL || old == cmf_pkg::MODE_LOOP) ? old : seqm[k]);
            rdc(cmf_pkg::OFF_STAT, v << 5);
            waitidle();
            rdc(cmf_pkg::OFF_STAT, 32'(seqm[k]) << 5);
            chk({txEnable, loopEnable, rxEnable}, {seqm[k] == cmf_pkg::MODE_NORMAL,
                seqm[k] == cmf_pkg::MODE_LOOP, seqm[k] < cmf_pkg::MODE_CONFIG
                && seqm[k] != cmf_pkg::MODE_SLEEP});
            old = seqm[k];
        end
        rst();
        rdc(cmf_pkg::OFF_MASK0, 32'(cmf_pkg::ACC_RESET));
        wr(cmf_pkg::OFF_CTRL, 32'ha0);
        rdc(cmf_pkg::OFF_CTRL, 32'(cmf_pkg::MODE_RESET) << 5);
        rdc(cmf_pkg::OFF_STAT, 32'(cmf_pkg::MODE_RESET) << 5);
        $display("mode test done");
        give_verdict();
    end
endmodule
